/* hdl/misi_pkg.sv */
// constants, register map and the helper function of the management interrupt block
package misi_pkg;

   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int unsigned REG_W  = 8;
   localparam int unsigned AXI_AW = 8;
   localparam int unsigned AXI_DW = 32;
   localparam int unsigned IRQ_W  = 2;

   // -----------------------------------------------------------------
   // register indices; byte address is four times the index
   // -----------------------------------------------------------------
   localparam logic [7:0] IDX_PIN_GROUP1_STATUS = 8'h15;
   localparam logic [7:0] IDX_GATE_A            = 8'h16;
   localparam logic [7:0] IDX_GATE_B_ROUTING    = 8'h17;
   localparam logic [7:0] IDX_PIN_GROUP2_GATE   = 8'h18;
   localparam logic [7:0] IDX_PIN_GROUP3_GATE   = 8'h19;
   localparam logic [7:0] IDX_PIN_GROUP4_GATE   = 8'h1A;
   localparam logic [7:0] IDX_IRQ_STATUS        = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK          = 8'h21;

   localparam logic [AXI_AW-1:0] ADDR_PIN_GROUP1_STATUS = {IDX_PIN_GROUP1_STATUS[5:0], 2'b00};
   localparam logic [AXI_AW-1:0] ADDR_GATE_A            = {IDX_GATE_A[5:0], 2'b00};
   localparam logic [AXI_AW-1:0] ADDR_GATE_B_ROUTING    = {IDX_GATE_B_ROUTING[5:0], 2'b00};
   localparam logic [AXI_AW-1:0] ADDR_PIN_GROUP2_GATE   = {IDX_PIN_GROUP2_GATE[5:0], 2'b00};
   localparam logic [AXI_AW-1:0] ADDR_PIN_GROUP3_GATE   = {IDX_PIN_GROUP3_GATE[5:0], 2'b00};
   localparam logic [AXI_AW-1:0] ADDR_PIN_GROUP4_GATE   = {IDX_PIN_GROUP4_GATE[5:0], 2'b00};
   localparam logic [AXI_AW-1:0] ADDR_IRQ_STATUS        = {IDX_IRQ_STATUS[5:0], 2'b00};
   localparam logic [AXI_AW-1:0] ADDR_IRQ_MASK          = {IDX_IRQ_MASK[5:0], 2'b00};

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [REG_W-1:0] RST_REG = 8'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int unsigned GA_PARPORT  = 1;
   localparam int unsigned GA_SERIAL2  = 2;
   localparam int unsigned GA_SERIAL1  = 3;
   localparam int unsigned GA_FLOPPY   = 4;
   localparam int unsigned GA_WATCHDOG = 7;
   localparam logic [REG_W-1:0] GA_WRITE_MASK = 8'h9E;

   localparam int unsigned GB_MOUSE        = 0;
   localparam int unsigned GB_KBD          = 1;
   localparam int unsigned GB_SMBUS        = 2;
   localparam int unsigned GB_RING1        = 3;
   localparam int unsigned GB_P12          = 4;
   localparam int unsigned GB_RING2        = 5;
   localparam int unsigned GB_ROUTE_SERIRQ = 6;
   localparam int unsigned GB_ROUTE_PIN    = 7;

   localparam int unsigned G3_FAN_SPEED = 5;

   localparam int unsigned IRQ_GROUP_ASSERT = 0;
   localparam int unsigned IRQ_PIN_EVENT    = 1;

   // -----------------------------------------------------------------
   // axi responses
   // -----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // write-one-to-clear with set winning over clear
   function automatic logic [REG_W-1:0] misi_w1c(input logic [REG_W-1:0] cur,
                                                 input logic [REG_W-1:0] set,
                                                 input logic [REG_W-1:0] clr);
      misi_w1c = (cur & ~clr) | set;
   endfunction : misi_w1c

endpackage : misi_pkg

/* hdl/misi_sync.sv */
// two flip-flop synchroniser for the eight group-one pins
`timescale 1ns/1ps
module misi_sync
   import misi_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic [REG_W-1:0] async_in,
   output logic      [REG_W-1:0] sync_out
);

   logic [REG_W-1:0] stage1;

   // stage1 feeds only the second stage
   always_ff @(posedge mclk) begin
      if (reset) begin
         stage1   <= RST_REG;
         sync_out <= RST_REG;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule : misi_sync

/* hdl/misi_top.sv */
// management interrupt status, gating and routing with an axi4-lite register slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module misi_top
   import misi_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              reset,
   // axi4-lite slave
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [AXI_DW-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [AXI_DW-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // group-one pins gpio_10 .. gpio_17, asynchronous
   input  wire logic [REG_W-1:0]  gpio_10_17,
   // enables for group-one pins, held in another register block
   input  wire logic [REG_W-1:0]  pin_group1_gate_in,
   // peripheral interrupt lines, same clock, live levels
   input  wire logic              parport_irq,
   input  wire logic              serial2_irq,
   input  wire logic              serial1_irq,
   input  wire logic              floppy_irq,
   input  wire logic              watchdog_irq,
   input  wire logic              mouse_irq,
   input  wire logic              kbd_irq,
   // sticky status bits held in the other status registers, same clock
   input  wire logic              smbus_status,
   input  wire logic              ring_ind_1,
   input  wire logic              kbd_port_p12,
   input  wire logic              ring_ind_2,
   input  wire logic [REG_W-1:0]  pin_group2_status,
   input  wire logic [REG_W-1:0]  pin_group3_status,
   input  wire logic [REG_W-1:0]  pin_group4_status,
   // outputs
   output logic                   group_mgmt_irq_n,
   output logic                   mgmt_irq_pin_n,
   output logic                   serirq_mgmt_req,
   output logic                   irq
);

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   logic [REG_W-1:0] pin_group1_event_status;
   logic [REG_W-1:0] periph_irq_gate_a;
   logic [REG_W-1:0] periph_irq_gate_b_routing;
   logic [REG_W-1:0] pin_group2_gate;
   logic [REG_W-1:0] pin_group3_gate;
   logic [REG_W-1:0] pin_group4_gate;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;

   // -----------------------------------------------------------------
   // pin synchronisation and edge detection
   // -----------------------------------------------------------------
   logic [REG_W-1:0] gpio_sync;
   logic [REG_W-1:0] gpio_prev;
   wire  [REG_W-1:0] gpio_rise;

   misi_sync u_sync (
      .mclk     (mclk),
      .reset    (reset),
      .async_in (gpio_10_17),
      .sync_out (gpio_sync)
   );

   always_ff @(posedge mclk) begin
      if (reset) begin
         gpio_prev <= RST_REG;
      end else begin
         gpio_prev <= gpio_sync;
      end
   end

   // an edge, not a level, so that a pin held high does not refill the bit forever
   assign gpio_rise = gpio_sync & ~gpio_prev;

   // -----------------------------------------------------------------
   // write channel
   // -----------------------------------------------------------------
   logic              aw_held;
   logic [AXI_AW-1:0] aw_addr;
   logic              w_held;
   logic [REG_W-1:0]  w_data;
   logic              w_lane0;

   wire do_write   = aw_held && w_held && !s_axi_bvalid;
   wire aw_take    = s_axi_awvalid && s_axi_awready;
   wire w_take     = s_axi_wvalid && s_axi_wready;

   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;

   always_ff @(posedge mclk) begin
      if (reset) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (aw_take) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         w_held  <= 1'b0;
         w_data  <= RST_REG;
         w_lane0 <= 1'b0;
      end else if (w_take) begin
         w_held  <= 1'b1;
         w_data  <= s_axi_wdata[REG_W-1:0];
         w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // byte lanes below the word are ignored on both channels
   function automatic logic [AXI_AW-1:0] word_addr(input logic [AXI_AW-1:0] a);
      word_addr = {a[AXI_AW-1:2], 2'b00};
   endfunction : word_addr

   // write decode
   wire [AXI_AW-1:0] wa = word_addr(aw_addr);
   wire hit_w_sts  = (wa == ADDR_PIN_GROUP1_STATUS);
   wire hit_w_ga   = (wa == ADDR_GATE_A);
   wire hit_w_gb   = (wa == ADDR_GATE_B_ROUTING);
   wire hit_w_g2   = (wa == ADDR_PIN_GROUP2_GATE);
   wire hit_w_g3   = (wa == ADDR_PIN_GROUP3_GATE);
   wire hit_w_g4   = (wa == ADDR_PIN_GROUP4_GATE);
   wire hit_w_is   = (wa == ADDR_IRQ_STATUS);
   wire hit_w_im   = (wa == ADDR_IRQ_MASK);
   wire hit_w_any  = hit_w_sts | hit_w_ga | hit_w_gb | hit_w_g2 | hit_w_g3 | hit_w_g4
                   | hit_w_is | hit_w_im;
   wire wr_en      = do_write && w_lane0;

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= hit_w_any ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // group-one event status
   // -----------------------------------------------------------------
   wire [REG_W-1:0] sts_clear = (wr_en && hit_w_sts) ? w_data : RST_REG;

   always_ff @(posedge mclk) begin
      if (reset) begin
         pin_group1_event_status <= RST_REG;
      end else begin
         // a new edge in the clearing cycle survives the clear
         pin_group1_event_status <= misi_w1c(pin_group1_event_status, gpio_rise,
                                             sts_clear);
      end
   end

   // -----------------------------------------------------------------
   // enable and routing registers
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         periph_irq_gate_a         <= RST_REG;
         periph_irq_gate_b_routing <= RST_REG;
         pin_group2_gate           <= RST_REG;
         pin_group3_gate           <= RST_REG;
         pin_group4_gate           <= RST_REG;
      end else if (wr_en) begin
         if (hit_w_ga) begin
            periph_irq_gate_a <= w_data & GA_WRITE_MASK;
         end
         if (hit_w_gb) begin
            periph_irq_gate_b_routing <= w_data;
         end
         if (hit_w_g2) begin
            pin_group2_gate <= w_data;
         end
         if (hit_w_g3) begin
            pin_group3_gate <= w_data;
         end
         if (hit_w_g4) begin
            pin_group4_gate <= w_data;
         end
      end
   end

   // -----------------------------------------------------------------
   // source vectors and gating
   // -----------------------------------------------------------------
   // peripheral lines are used live, so their status drops only with the source
   wire [REG_W-1:0] periph_src_a = {watchdog_irq, 1'b0, 1'b0, floppy_irq,
                                    serial1_irq, serial2_irq, parport_irq, 1'b0};
   wire [REG_W-1:0] periph_src_b = {1'b0, 1'b0, ring_ind_2, kbd_port_p12,
                                    ring_ind_1, smbus_status, kbd_irq, mouse_irq};
   wire [REG_W-1:0] gate_b_srcs  = periph_irq_gate_b_routing
                                 & ~(8'h01 << GB_ROUTE_SERIRQ) & ~(8'h01 << GB_ROUTE_PIN);

   wire [REG_W-1:0] hit_g1 = pin_group1_event_status & pin_group1_gate_in;
   wire [REG_W-1:0] hit_ga = periph_src_a & periph_irq_gate_a;
   wire [REG_W-1:0] hit_gb = periph_src_b & gate_b_srcs;
   wire [REG_W-1:0] hit_g2 = pin_group2_status & pin_group2_gate;
   wire [REG_W-1:0] hit_g3 = pin_group3_status & pin_group3_gate;
   wire [REG_W-1:0] hit_g4 = pin_group4_status & pin_group4_gate;

   wire next_group_active = |{hit_g1, hit_ga, hit_gb, hit_g2, hit_g3, hit_g4};
   wire route_serirq      = periph_irq_gate_b_routing[GB_ROUTE_SERIRQ];
   wire route_pin         = periph_irq_gate_b_routing[GB_ROUTE_PIN];

   logic group_active;

   always_ff @(posedge mclk) begin
      if (reset) begin
         group_active     <= 1'b0;
         group_mgmt_irq_n <= 1'b1;
         mgmt_irq_pin_n   <= 1'b1;
         serirq_mgmt_req  <= 1'b0;
      end else begin
         group_active     <= next_group_active;
         group_mgmt_irq_n <= ~next_group_active;
         mgmt_irq_pin_n   <= ~(next_group_active && route_pin);
         serirq_mgmt_req  <= next_group_active && route_serirq;
      end
   end

   // -----------------------------------------------------------------
   // software interrupt status and mask
   // -----------------------------------------------------------------
   wire [IRQ_W-1:0] irq_set;
   wire [IRQ_W-1:0] irq_clr = (wr_en && hit_w_is) ? w_data[IRQ_W-1:0] : RST_IRQ;

   assign irq_set[IRQ_GROUP_ASSERT] = next_group_active && !group_active;
   assign irq_set[IRQ_PIN_EVENT]    = |gpio_rise;

   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_status <= RST_IRQ;
         irq_mask   <= RST_IRQ;
         irq        <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
         if (wr_en && hit_w_im) begin
            irq_mask <= w_data[IRQ_W-1:0];
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // -----------------------------------------------------------------
   // read channel
   // -----------------------------------------------------------------
   wire [AXI_AW-1:0] ra = word_addr(s_axi_araddr);
   wire ar_take = s_axi_arvalid && s_axi_arready;
   logic [REG_W-1:0] rd_sel;
   logic             rd_hit;

   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_sel = RST_REG;
      rd_hit = 1'b1;
      unique case (ra)
         ADDR_PIN_GROUP1_STATUS: rd_sel = pin_group1_event_status;
         ADDR_GATE_A:            rd_sel = periph_irq_gate_a;
         ADDR_GATE_B_ROUTING:    rd_sel = periph_irq_gate_b_routing;
         ADDR_PIN_GROUP2_GATE:   rd_sel = pin_group2_gate;
         ADDR_PIN_GROUP3_GATE:   rd_sel = pin_group3_gate;
         ADDR_PIN_GROUP4_GATE:   rd_sel = pin_group4_gate;
         ADDR_IRQ_STATUS:        rd_sel = {{(REG_W-IRQ_W){1'b0}}, irq_status};
         ADDR_IRQ_MASK:          rd_sel = {{(REG_W-IRQ_W){1'b0}}, irq_mask};
         default:                rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {{(AXI_DW-REG_W){1'b0}}, rd_sel};
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : misi_top

/* verification/misi_chk.sv */
// concurrent checks on the ports of the management interrupt block
`timescale 1ns/1ps
module misi_chk
   import misi_pkg::*;
(
   input wire logic              mclk,
   input wire logic              reset,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [AXI_DW-1:0] s_axi_rdata,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic              group_mgmt_irq_n,
   input wire logic              mgmt_irq_pin_n,
   input wire logic              serirq_mgmt_req,
   input wire logic              irq
);
   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   chk_reset_out: assert property ($fell(reset) |-> group_mgmt_irq_n && mgmt_irq_pin_n
      && !serirq_mgmt_req && !irq && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not idle after reset");
   chk_pin_route: assert property (!mgmt_irq_pin_n |-> !group_mgmt_irq_n)
      else $error("pin asserted without group output");
   chk_ser_route: assert property (serirq_mgmt_req |-> !group_mgmt_irq_n)
      else $error("serial request without group output");
   chk_rdata_hi: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data above the register byte");
   chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && !s_axi_bvalid |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read data dropped early");
   chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated after handshake");
   chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated after handshake");
endmodule : misi_chk

/* verification/misi_host.sv */
// host-side receiver of the routed management interrupt, counts assertions
`timescale 1ns/1ps
module misi_host (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic mgmt_irq_pin_n,
   input  wire logic serirq_mgmt_req,
   output int        pin_hits,
   output int        ser_hits
);
   logic pin_q = 1'b1;
   logic ser_q = 1'b0;
   // edge counting, so a held request is seen once; reset clears the counts
   always @(posedge mclk) begin
      pin_q <= mgmt_irq_pin_n;
      ser_q <= serirq_mgmt_req;
      if (reset) begin
         pin_hits <= 0;
         ser_hits <= 0;
      end else begin
         if (pin_q && !mgmt_irq_pin_n) pin_hits <= pin_hits + 1;
         if (!ser_q && serirq_mgmt_req) ser_hits <= ser_hits + 1;
      end
   end
endmodule : misi_host

/* verification/misi_top_tb.sv */
// self-checking bench for the management interrupt block
`timescale 1ns/1ps
module misi_top_tb
   import misi_pkg::*;
;
   logic              mclk = 1'b0;
   logic              reset = 1'b1;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic [AXI_DW-1:0] wdata = '0;
   logic [3:0]        wstrb = '0;
   logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]        gpio = '0, gate1 = '0;
   logic [34:0]       src = '0;
   logic [31:0]       rs = 32'h00000FA8;
   wire               awready, wready, bvalid, arready, rvalid, gnt_n, pin_n, ser, irq;
   wire  [1:0]        bresp, rresp;
   wire  [31:0]       rdata;
   int                n_errors = 0, tests_run = 0, cyc = 0, pin_hits, ser_hits;
   logic [7:0]        gaddr [5] = '{ADDR_GATE_A, ADDR_GATE_B_ROUTING, ADDR_PIN_GROUP2_GATE,
                                   ADDR_PIN_GROUP3_GATE, ADDR_PIN_GROUP4_GATE};
   logic [7:0]        amap [8] = '{ADDR_PIN_GROUP1_STATUS, ADDR_GATE_A, ADDR_GATE_B_ROUTING,
                                  ADDR_PIN_GROUP2_GATE, ADDR_PIN_GROUP3_GATE,
                                  ADDR_PIN_GROUP4_GATE, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};

   misi_top dut (
      .mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .gpio_10_17(gpio), .pin_group1_gate_in(gate1), .parport_irq(src[0]),
      .serial2_irq(src[1]), .serial1_irq(src[2]), .floppy_irq(src[3]),
      .watchdog_irq(src[4]), .mouse_irq(src[5]), .kbd_irq(src[6]),
      .smbus_status(src[7]), .ring_ind_1(src[8]), .kbd_port_p12(src[9]),
      .ring_ind_2(src[10]), .pin_group2_status(src[18:11]),
      .pin_group3_status(src[26:19]), .pin_group4_status(src[34:27]),
      .group_mgmt_irq_n(gnt_n), .mgmt_irq_pin_n(pin_n), .serirq_mgmt_req(ser), .irq(irq));

   misi_host host (.mclk(mclk), .reset(reset), .mgmt_irq_pin_n(pin_n),
      .serirq_mgmt_req(ser), .pin_hits(pin_hits), .ser_hits(ser_hits));

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [7:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs[7:0];
   endfunction : xs

   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t value %h expected %h", $time, g, e);
      end
   endtask : chk_val

   task automatic chk_pin(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t output %b expected %b", $time, g, e);
      end
   endtask : chk_pin

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er,
                     input logic [3:0] s = 4'hF);
      @(posedge mclk);
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk_val(bresp, er);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      @(posedge mclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk_val(rdata, {24'h000000, e});
      chk_val(rresp, er);
   endtask : rd

   task automatic tally_and_finish();
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   // -----------------------------------------------------------------
   // clock, watchdog, sequence
   // -----------------------------------------------------------------
   initial begin
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   initial begin
      logic [7:0]  gv [5];
      logic [7:0]  st, m;
      logic [34:0] gen;
      logic        act;
      int          ph, sh;
      ph = 0;
      sh = 0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      foreach (amap[i]) rd(amap[i], 8'h00, RESP_OKAY);
      wr(8'hFC, 8'hFF, RESP_SLVERR);
      rd(8'hFC, 8'h00, RESP_SLVERR);
      wr(ADDR_GATE_A, 8'hFF, RESP_OKAY, 4'hE);
      rd(ADDR_GATE_A, 8'h00, RESP_OKAY);
      // one source at a time under random gates; last pass has none
      for (int i = 0; i < 36; i++) begin
         foreach (gv[k]) gv[k] = xs();
         foreach (gv[k]) wr(gaddr[k], gv[k], RESP_OKAY);
         gv[0] = gv[0] & GA_WRITE_MASK;
         rd(gaddr[i % 5], gv[i % 5], RESP_OKAY);
         gen = {gv[4], gv[3], gv[2], gv[1][5:0], gv[0][7], gv[0][4:1]};
         act = (i < 35) ? gen[i] : 1'b0;
         ph += int'(act & gv[1][7]);
         sh += int'(act & gv[1][6]);
         src <= 35'h1 << i;
         repeat (3) @(posedge mclk);
         chk_pin(gnt_n, !act);
         chk_pin(pin_n, !(act & gv[1][7]));
         chk_pin(ser, act & gv[1][6]);
         src <= '0;
         repeat (3) @(posedge mclk);
         chk_pin(gnt_n, 1'b1);
      end
      chk_val(pin_hits, ph);
      chk_val(ser_hits, sh);
      // pin events, write-one-to-clear and the interrupt
      wr(ADDR_IRQ_STATUS, 8'h03, RESP_OKAY);
      wr(ADDR_IRQ_MASK, 8'h02, RESP_OKAY);
      st = xs() | 8'h01;
      gate1 <= 8'hFF;
      gpio <= st;
      repeat (8) @(posedge mclk);
      chk_pin(irq, 1'b1);
      chk_pin(gnt_n, 1'b0);
      rd(ADDR_PIN_GROUP1_STATUS, st, RESP_OKAY);
      rd(ADDR_IRQ_STATUS, 8'h03, RESP_OKAY);
      m = xs();
      gpio <= 8'h00;
      wr(ADDR_PIN_GROUP1_STATUS, m, RESP_OKAY);
      st = st & ~m;
      rd(ADDR_PIN_GROUP1_STATUS, st, RESP_OKAY);
      wr(ADDR_IRQ_MASK, 8'h00, RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk_pin(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 8'h02, RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk_pin(irq, 1'b1);
      wr(ADDR_IRQ_STATUS, 8'h02, RESP_OKAY);
      wr(ADDR_PIN_GROUP1_STATUS, 8'hFF, RESP_OKAY);
      repeat (2) @(posedge mclk);
      chk_pin(irq, 1'b0);
      chk_pin(gnt_n, 1'b1);
      tally_and_finish();
   end
endmodule : misi_top_tb

bind misi_top misi_chk chk_i (.mclk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .group_mgmt_irq_n, .mgmt_irq_pin_n,
   .serirq_mgmt_req, .irq);
